// ==== rtl/sms_pkg.sv ====
// constants and types used by the serial port; its synchroniser takes none of them
// assumes one 100 MHz bus clock and no software-visible registers
package sms_pkg;
  localparam int unsigned CLOCK_PERIOD_NS = 10;
  localparam int unsigned FRAME_BITS      = 8;
  localparam int unsigned HALF_W          = 10;
  localparam int unsigned EDGE_W          = 4;
  localparam int unsigned SYNC_STAGES     = 2;
  localparam int unsigned DIV_FASTEST     = 2;
  localparam int unsigned DIV_SLOWEST     = 2048;
  localparam int unsigned SLAVE_MIN_DIV   = 4;
  localparam logic [EDGE_W-1:0] EDGE_LAST       = 4'hf;
  localparam logic [HALF_W-1:0] HALF_RESET      = 10'h000;
  localparam logic [7:0]        SHIFT_RESET     = 8'h00;
  localparam logic [2:0]        BIT_LAST        = 3'h7;

  typedef enum logic [3:0] {
    SMS_IDLE  = 4'h1,
    SMS_LEAD  = 4'h2,
    SMS_SHIFT = 4'h4,
    SMS_LAG   = 4'h8
  } sms_state_type;
endpackage

// ==== rtl/sms_sync.sv ====
// two flip-flop synchroniser for a group of pin levels
// assumes the inputs are levels from outside the bus clock domain
`timescale 1ns/1ps
module sms_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] reset_value,
  output      logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] hold_reg;

  // stages keep the level xored with its idle value, so a zero reset reads as idle
  // first stage is read only by the second stage
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_reg <= '0;
      hold_reg <= '0;
    end
    else
    begin
      meta_reg <= async_in ^ reset_value;
      hold_reg <= meta_reg;
    end
  end

  assign sync_out = hold_reg ^ reset_value;
endmodule

// ==== rtl/sms_top.sv ====
// master/slave serial port shifting 8-bit frames, one bus clock domain
// assumes pins resolved outside from out/oe; control comes from same-clock logic
// Contract
// - port works as clock-generating master or as clock-receiving slave
// - master clock period programmable from 2 to 2048 bus clocks
// - bit order select clear shifts msb first, set shifts lsb first
// - selected slave drives its data output within three cycles of select falling at the pin
// - deselected slave releases its data output within three cycles of select rising at the pin
`timescale 1ns/1ps
module sms_top (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        master_mode,
  input  wire logic        lsb_first_select,
  input  wire logic        clock_polarity,
  input  wire logic        clock_phase,
  input  wire logic [9:0]  half_period_m1,
  input  wire logic [7:0]  tx_data,
  input  wire logic        start,
  output      logic        ready,
  output      logic        done,
  output      logic [7:0]  rx_data,
  output      logic        rx_valid,
  input  wire logic        serial_clock_pin_in,
  output      logic        serial_clock_pin_out,
  output      logic        serial_clock_pin_oe,
  input  wire logic        select_n_in,
  output      logic        select_n_out,
  output      logic        select_n_oe,
  input  wire logic        mosi_in,
  output      logic        mosi_out,
  output      logic        mosi_oe,
  input  wire logic        miso_in,
  output      logic        miso_out,
  output      logic        miso_oe
);
  sms_pkg::sms_state_type            state_reg;
  logic [sms_pkg::HALF_W-1:0]        half_reg;
  logic [sms_pkg::HALF_W-1:0]        half_hold_reg;
  logic [sms_pkg::EDGE_W-1:0]        edge_reg;
  logic [7:0]                        tx_reg;
  logic [7:0]                        rx_sh_reg;
  logic [7:0]                        rx_sh_next;
  logic [2:0]                        bit_reg;
  logic                              first_reg;
  logic [1:0]                        sample_pipe_reg;
  logic                              sclk_prev_reg;
  logic                              sel_prev_reg;
  logic [3:0]                        pins_sync;
  logic                              sclk_s;
  logic                              sel_n_s;
  logic                              mosi_s;
  logic                              miso_s;
  logic                              m_edge;
  logic                              m_active;
  logic                              s_edge;
  logic                              ev_edge;
  logic                              ev_lead;
  logic                              shift_ev;
  logic                              sample_now;
  logic                              sample_ev;
  logic                              in_bit;
  logic                              sel_fall;
  logic                              load_ev;
  logic [7:0]                        tx_next;

  // select idles high, so it resets to deselected
  sms_sync #(
    .WIDTH (4)
  ) u_sync (
    .clock       (clock),
    .resetn      (resetn),
    .async_in    ({serial_clock_pin_in, select_n_in, mosi_in, miso_in}),
    .reset_value (4'h4),
    .sync_out    (pins_sync)
  );
  assign {sclk_s, sel_n_s, mosi_s, miso_s} = pins_sync;

  assign m_active = (state_reg == sms_pkg::SMS_LEAD) || (state_reg == sms_pkg::SMS_SHIFT);
  assign m_edge   = master_mode && m_active && (half_reg == sms_pkg::HALF_RESET);
  assign s_edge   = !master_mode && !sel_n_s && (sclk_s != sclk_prev_reg);
  assign sel_fall = !master_mode && !sel_n_s && sel_prev_reg;
  assign ev_edge  = m_edge || s_edge;
  // leading edge leaves the idle level
  assign ev_lead  = master_mode ? !edge_reg[0] : (sclk_s != clock_polarity);
  assign shift_ev   = ev_edge && (clock_phase ? (ev_lead && !first_reg) : !ev_lead);
  assign sample_now = ev_edge && (clock_phase ? !ev_lead : ev_lead);
  // master samples the synchronised return line two cycles late, matching its latency
  assign sample_ev  = master_mode ? sample_pipe_reg[1] : sample_now;
  assign in_bit     = master_mode ? miso_s : mosi_s;
  assign rx_sh_next = lsb_first_select ? {in_bit, rx_sh_reg[7:1]} : {rx_sh_reg[6:0], in_bit};

  // master sequencer: lead, sixteen clock edges, lag
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg     <= sms_pkg::SMS_IDLE;
      half_reg      <= sms_pkg::HALF_RESET;
      half_hold_reg <= sms_pkg::HALF_RESET;
      edge_reg      <= '0;
      done          <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (state_reg)
        sms_pkg::SMS_IDLE:
        begin
          if (master_mode && start)
          begin
            half_hold_reg <= half_period_m1;
            half_reg      <= half_period_m1;
            edge_reg      <= '0;
            state_reg     <= sms_pkg::SMS_LEAD;
          end
        end
        sms_pkg::SMS_LEAD, sms_pkg::SMS_SHIFT:
        begin
          if (!master_mode)
            state_reg <= sms_pkg::SMS_IDLE;
          else if (half_reg == sms_pkg::HALF_RESET)
          begin
            half_reg <= half_hold_reg;
            edge_reg <= edge_reg + 4'h1;
            if (edge_reg == sms_pkg::EDGE_LAST)
              state_reg <= sms_pkg::SMS_LAG;
            else
              state_reg <= sms_pkg::SMS_SHIFT;
          end
          else
            half_reg <= half_reg - 10'h001;
        end
        sms_pkg::SMS_LAG:
        begin
          if (half_reg == sms_pkg::HALF_RESET)
          begin
            state_reg <= sms_pkg::SMS_IDLE;
            done      <= 1'b1;
          end
          else
            half_reg <= half_reg - 10'h001;
        end
        default:
          state_reg <= sms_pkg::SMS_IDLE;
      endcase
    end
  end

  // master pins
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      serial_clock_pin_out <= 1'b0;
      serial_clock_pin_oe  <= 1'b0;
      select_n_out         <= 1'b1;
      select_n_oe          <= 1'b0;
      mosi_oe              <= 1'b0;
      ready                <= 1'b0;
    end
    else
    begin
      serial_clock_pin_oe <= master_mode;
      select_n_oe         <= master_mode;
      mosi_oe             <= master_mode;
      ready               <= master_mode && (state_reg == sms_pkg::SMS_IDLE) && !start;
      if (m_edge)
        serial_clock_pin_out <= !serial_clock_pin_out;
      else if (!m_active)
        serial_clock_pin_out <= clock_polarity;
      if (state_reg == sms_pkg::SMS_IDLE)
        select_n_out <= !(master_mode && start);
      else if (state_reg == sms_pkg::SMS_LAG && half_reg == sms_pkg::HALF_RESET)
        select_n_out <= 1'b1;
    end
  end

  // slave data output follows the synchronised select
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      miso_oe <= 1'b0;
    else
      miso_oe <= !master_mode && !sel_n_s;
  end

  // transmit shifter, shared by both roles
  assign load_ev = (master_mode && state_reg == sms_pkg::SMS_IDLE && start) || sel_fall;

  always_comb
  begin
    tx_next = tx_reg;
    if (load_ev)
      tx_next = tx_data;
    else if (shift_ev)
      tx_next = lsb_first_select ? {1'b0, tx_reg[7:1]} : {tx_reg[6:0], 1'b0};
  end

  // data pins take the next shifter bit, so the first bit is set up before the first edge
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_reg    <= sms_pkg::SHIFT_RESET;
      first_reg <= 1'b0;
      mosi_out  <= 1'b0;
      miso_out  <= 1'b0;
    end
    else
    begin
      tx_reg    <= tx_next;
      mosi_out  <= lsb_first_select ? tx_next[0] : tx_next[7];
      miso_out  <= lsb_first_select ? tx_next[0] : tx_next[7];
      if (load_ev)
        first_reg <= 1'b1;
      else if (ev_edge)
        first_reg <= 1'b0;
    end
  end

  // receive shifter; slave relies on the far master's slow clock to see every edge
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      sample_pipe_reg <= 2'h0;
      sclk_prev_reg   <= 1'b0;
      sel_prev_reg    <= 1'b1;
      rx_sh_reg       <= sms_pkg::SHIFT_RESET;
      bit_reg         <= 3'h0;
      rx_data         <= sms_pkg::SHIFT_RESET;
      rx_valid        <= 1'b0;
    end
    else
    begin
      sample_pipe_reg <= {sample_pipe_reg[0], master_mode && sample_now};
      sclk_prev_reg   <= sclk_s;
      sel_prev_reg    <= sel_n_s;
      rx_valid        <= 1'b0;
      if (load_ev)
        bit_reg <= 3'h0;
      else if (sample_ev)
      begin
        rx_sh_reg <= rx_sh_next;
        bit_reg   <= bit_reg + 3'h1;
        if (bit_reg == sms_pkg::BIT_LAST)
        begin
          rx_data  <= rx_sh_next;
          rx_valid <= 1'b1;
        end
      end
    end
  end

  // helper: cycles since the last master clock toggle
  logic [11:0] gap_reg;
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      gap_reg <= 12'h000;
    else if (m_edge || state_reg == sms_pkg::SMS_IDLE)
      gap_reg <= 12'h000;
    else
      gap_reg <= gap_reg + 12'h001;
  end

  sequence s_select_low;
    master_mode && $fell(select_n_out);
  endsequence

  a_slave_drive: assert property (@(posedge clock) disable iff (!resetn)
    (!master_mode && !sel_n_s) |=> miso_oe)
    else $error("slave output not driven after select");
  a_slave_release: assert property (@(posedge clock) disable iff (!resetn)
    (!master_mode && $rose(sel_n_s)) |=> !miso_oe)
    else $error("slave output not released after deselect");
  a_master_rate: assert property (@(posedge clock) disable iff (!resetn)
    (master_mode && m_edge && state_reg == sms_pkg::SMS_SHIFT)
      |-> gap_reg == 12'({2'b00, half_hold_reg}) ##1 $changed(serial_clock_pin_out))
    else $error("master clock half period wrong");
  a_lead_time: assert property (@(posedge clock) disable iff (!resetn)
    s_select_low |-> serial_clock_pin_out == clock_polarity
      && state_reg == sms_pkg::SMS_LEAD && half_reg == half_hold_reg)
    else $error("clock edge too soon after select");
  a_lag_time: assert property (@(posedge clock) disable iff (!resetn)
    (master_mode && $rose(select_n_out)) |-> $past(state_reg) == sms_pkg::SMS_LAG)
    else $error("select released outside lag");
  a_master_drives: assert property (@(posedge clock) disable iff (!resetn)
    master_mode |=> (serial_clock_pin_oe && select_n_oe && mosi_oe))
    else $error("master pins not driven");
  a_bit_order: assert property (@(posedge clock) disable iff (!resetn)
    (master_mode && shift_ev && !lsb_first_select) |=> mosi_out == $past(tx_reg[6]))
    else $error("msb first order broken");
endmodule

// ==== verif/sms_peer.sv ====
// serial peripheral model for the far side in master role, all four clock modes
// assumes polarity and phase match the port's setting and change only while deselected
`timescale 1ns/1ps
module sms_peer (
  input  wire logic       sclk,
  input  wire logic       sel_n,
  input  wire logic       mosi,
  input  wire logic       lsb,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic [7:0]      rx
);
  logic [7:0] sh;
  logic       first = 1'b0;
  initial miso = 1'b1;
  always @(negedge sel_n)
  begin
    sh = tx;
    rx = 8'h00;
    first = 1'b1;
    miso = lsb ? tx[0] : tx[7];
  end
  // sample on leading edges in phase 0, trailing in phase 1;
  // in phase 1 the first leading edge keeps the bit already shown at select
  always @(sclk)
  begin
    if (sel_n === 1'b0)
    begin
      if ((sclk !== cpol) ^ cpha)
        rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
      else if (!first)
      begin
        sh = lsb ? sh >> 1 : sh << 1;
        miso = lsb ? sh[0] : sh[7];
      end
      first = 1'b0;
    end
  end
  // released line: show the inverse, not a stale bit
  always @(posedge sel_n) miso = ~miso;
endmodule

// ==== verif/test_sms_top.sv ====
// testbench for the serial port: master frames against the peer model,
// slave frames driven by hand at a quarter of the bus clock or slower
`timescale 1ns/1ps
module test_sms_top;
  logic clock = 1'b0, resetn = 1'b0, mm = 1'b1, lsb = 1'b0, start = 1'b0;
  logic [9:0] hm1 = 10'h000;
  logic [7:0] tx = 8'h00, ptx = 8'h00, prx, rx_data;
  logic ready, done, rx_valid, sc_o, sc_oe, sl_o, sl_oe, mo_o, mo_oe, mi_o, mi_oe, pmiso;
  logic tsc = 1'b0, tsl = 1'b1, tmo = 1'b0;
  logic cpol = 1'b0, cpha = 1'b0;
  int n_fail = 0, total_checks = 0;
  int n_valid = 0;
  wire sc_w = sc_oe ? sc_o : tsc;
  wire sl_w = sl_oe ? sl_o : tsl;
  wire mo_w = mo_oe ? mo_o : tmo;
  wire mi_w = mi_oe ? mi_o : pmiso;
  always #5 clock = ~clock;
  // counts one-cycle receive pulses while they stand
  always @(negedge clock) if (rx_valid === 1'b1) n_valid++;
  sms_top sms_top_i (.clock(clock), .resetn(resetn), .master_mode(mm), .lsb_first_select(lsb),
    .clock_polarity(cpol), .clock_phase(cpha), .half_period_m1(hm1), .tx_data(tx), .start(start),
    .ready(ready), .done(done), .rx_data(rx_data), .rx_valid(rx_valid), .serial_clock_pin_in(sc_w),
    .serial_clock_pin_out(sc_o), .serial_clock_pin_oe(sc_oe), .select_n_in(sl_w), .select_n_out(sl_o),
    .select_n_oe(sl_oe), .mosi_in(mo_w), .mosi_out(mo_o), .mosi_oe(mo_oe), .miso_in(mi_w),
    .miso_out(mi_o), .miso_oe(mi_oe));
  sms_peer sms_peer_i (.sclk(sc_w), .sel_n(sl_w), .mosi(mo_w), .lsb(lsb), .cpol(cpol), .cpha(cpha),
    .tx(ptx), .miso(pmiso), .rx(prx));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic master_frame(input logic pl, input logic ph, input logic b, input logic [9:0] h,
                              input logic [7:0] d, input logic [7:0] p);
    int c, s0, f0, l0, tg, w, v0;
    logic ps;
    mm = 1'b1; cpol = pl; cpha = ph; lsb = b; hm1 = h; tx = d; ptx = p;
    // let the idle clock level settle before select falls
    repeat (2) @(negedge clock);
    w = 0;
    while (ready !== 1'b1 && w < 50)
    begin
      @(negedge clock);
      w++;
    end
    chk("ready", 1, ready);
    v0 = n_valid;
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    c = 0; tg = 0; f0 = 0; l0 = 0; ps = sc_w;
    s0 = (sl_w === 1'b0) ? 0 : -1;
    while (done !== 1'b1 && c < 40000)
    begin
      @(negedge clock);
      c++;
      if (sl_w === 1'b0 && s0 < 0) s0 = c;
      if (sc_w !== ps)
      begin
        if (tg == 0) f0 = c;
        l0 = c;
        tg++;
        ps = sc_w;
      end
    end
    chk("done pulse", 1, done);
    chk("select released with done", 1, sl_w);
    chk("clock edges", 16, tg);
    chk("lead", h + 1, f0 - s0);
    chk("lag", h + 1, c - l0);
    chk("edge span", 15 * (h + 1), l0 - f0);
    chk("peer rx", d, prx);
    repeat (6) @(negedge clock);
    chk("master rx", p, rx_data);
    chk("master rx pulses", v0 + 1, n_valid);
  endtask
  task automatic slave_frame(input logic b, input logic [7:0] d, input logic [7:0] m);
    int c, v0;
    logic [7:0] got;
    mm = 1'b0; cpol = 1'b0; cpha = 1'b0; lsb = b; tx = d; got = 8'h00;
    v0 = n_valid;
    repeat (3) @(negedge clock);
    tsl = 1'b0;
    c = 0;
    while (mi_oe !== 1'b1 && c < 20)
    begin
      @(negedge clock);
      c++;
    end
    chk("access cycles", 3, c);
    repeat (4) @(negedge clock);
    for (int i = 0; i < 8; i++)
    begin
      tmo = b ? m[i] : m[7 - i];
      repeat (4) @(negedge clock);
      tsc = 1'b1;
      got = b ? {mi_w, got[7:1]} : {got[6:0], mi_w};
      repeat (4) @(negedge clock);
      tsc = 1'b0;
    end
    repeat (6) @(negedge clock);
    chk("slave rx", m, rx_data);
    chk("slave rx pulses", v0 + 1, n_valid);
    chk("slave tx", d, got);
    tsl = 1'b1;
    c = 0;
    while (mi_oe !== 1'b0 && c < 20)
    begin
      @(negedge clock);
      c++;
    end
    chk("release cycles", 3, c);
  endtask
  initial
  begin
    #250000;
    n_fail++;
    report_and_stop();
  end
  initial
  begin
    repeat (3) @(negedge clock);
    resetn = 1'b1;
    master_frame(1'b0, 1'b0, 1'b0, 10'h000, 8'ha5, 8'h3c);
    master_frame(1'b0, 1'b0, 1'b1, 10'h000, 8'h96, 8'h81);
    master_frame(1'b0, 1'b0, 1'b1, 10'h3ff, 8'h1e, 8'hc2);
    master_frame(1'b1, 1'b1, 1'b0, 10'h001, 8'h69, 8'h47);
    slave_frame(1'b0, 8'h5a, 8'hd1);
    slave_frame(1'b1, 8'h0f, 8'h8c);
    report_and_stop();
  end
endmodule
